/* rtl/lke_regs.svh */
/*
 Register map, field positions, reset values and legacy port numbers
 of the legacy keyboard emulation block.
 Assumes it is included by bare name from the design files.
*/
`ifndef LKE_REGS_SVH
`define LKE_REGS_SVH

// Register byte offsets
`define LKE_OFF_CTRL 12'h100
`define LKE_OFF_INPUT 12'h104
`define LKE_OFF_OUTPUT 12'h108
`define LKE_OFF_STATUS 12'h10C

// Control register fields
`define LKE_CTRL_EMU_ON 0
`define LKE_CTRL_EMU_IRQ 1
`define LKE_CTRL_CHAR_PEND 2
`define LKE_CTRL_IRQ_EN 3
`define LKE_CTRL_EXT_EN 4
`define LKE_CTRL_A20_SEQ 5
`define LKE_CTRL_KBD_SEEN 6
`define LKE_CTRL_MOUSE_SEEN 7
`define LKE_CTRL_A20_LEVEL 8

// Status register fields
`define LKE_ST_OUT_FULL 0
`define LKE_ST_IN_FULL 1
`define LKE_ST_FLAG 2
`define LKE_ST_CMD 3
`define LKE_ST_INHIBIT 4
`define LKE_ST_AUX_FULL 5
`define LKE_ST_TIMEOUT 6
`define LKE_ST_PARITY 7

// Reset values
`define LKE_CTRL_RESET 5'h00
`define LKE_BYTE_RESET 8'h00
`define LKE_WORD_ZERO 32'h0000_0000

// Legacy I/O ports and the gate A20 command
`define LKE_PORT_DATA 16'h0060
`define LKE_PORT_CMD 16'h0064
`define LKE_A20_CMD 8'hD1
`define LKE_A20_DATA_BIT 1

`endif

/* rtl/lke_pkg.sv */
/*
 Types shared by the legacy keyboard emulation files.
 Assumes nothing of its surroundings.
*/
package lke_pkg;

	// Which legacy port a host I/O access hits
	typedef enum logic [1:0] {
		LKE_PORT_NONE = 2'b00,
		LKE_PORT_DATA = 2'b01,
		LKE_PORT_CMD = 2'b10
	} lke_port_t;

	// AHB transfer types
	typedef enum logic [1:0] {
		LKE_HT_IDLE = 2'b00,
		LKE_HT_BUSY = 2'b01,
		LKE_HT_NONSEQ = 2'b10,
		LKE_HT_SEQ = 2'b11
	} lke_htrans_t;

endpackage

/* rtl/lke_edge_flag.sv */
/*
 Sticky flag set by a rising edge of a level input, cleared by a
 one-cycle clear strobe. Assumes the level is synchronous to clk.
*/
`timescale 1ns/1ps

module lke_edge_flag
(
	input wire logic clk, // Block clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic level, // Watched interrupt level
	input wire logic clr, // Clear strobe from software
	output logic flag // Sticky edge flag
);

	logic prev; // Level one cycle ago

	// Remember last level for edge detection
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			prev <= 1'b0;
		else
			prev <= level;
	end

	// Set beats clear so an edge in the clear cycle is kept
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			flag <= 1'b0;
		else if (level && !prev)
			flag <= 1'b1;
		else if (clr)
			flag <= 1'b0;
	end

endmodule

/* rtl/lke_io_decode.sv */
/*
 Decodes host I/O strobes against the legacy data and command ports.
 Assumes one-cycle strobes synchronous to the block clock.
*/
`timescale 1ns/1ps
`include "lke_regs.svh"

module lke_io_decode
#(
	parameter int IO_AW = 16 // I/O address width
)
(
	input wire logic [IO_AW-1:0] io_addr, // Host I/O address
	input wire logic io_wr, // Write strobe
	input wire logic io_rd, // Read strobe
	input wire logic enable, // Decoding allowed
	output logic wr_data, // Write to data port
	output logic wr_cmd, // Write to command port
	output logic rd_data, // Read of data port
	output logic rd_cmd // Read of command port
);

	lke_pkg::lke_port_t hit; // Port hit by the address
	logic [15:0] addr16; // Address widened to port width

	assign addr16 = 16'(io_addr);

	// Port match; nothing is claimed while emulation is off
	always_comb
	begin
		hit = lke_pkg::LKE_PORT_NONE;
		if (!enable)
			hit = lke_pkg::LKE_PORT_NONE;
		else if (addr16 == `LKE_PORT_DATA)
			hit = lke_pkg::LKE_PORT_DATA;
		else if (addr16 == `LKE_PORT_CMD)
			hit = lke_pkg::LKE_PORT_CMD;
	end

	assign wr_data = io_wr && (hit == lke_pkg::LKE_PORT_DATA);
	assign wr_cmd = io_wr && (hit == lke_pkg::LKE_PORT_CMD);
	assign rd_data = io_rd && (hit == lke_pkg::LKE_PORT_DATA);
	assign rd_cmd = io_rd && (hit == lke_pkg::LKE_PORT_CMD);

endmodule

/* rtl/lke_top.sv */
/*
 Legacy keyboard and mouse emulation: AHB-Lite register slave,
 legacy port snooping, gate A20 tracking and interrupt generation.
 Assumes host I/O strobes and keyboard controller lines are
 synchronous to hclk, and a single AHB-Lite master.
*/
`timescale 1ns/1ps
`include "lke_regs.svh"

// Operation
// - Control bit 8 shows gate A20 level
// - During sequence, data write compared to A20
// - Mouse line edge sets bit 7, W1C
// - Keyboard line edge sets bit 6, W1C
// - Command D1H sets A20 sequence bit
// - Other command byte clears A20 sequence
// - Pass-through enable routes controller interrupts
// - Pass-through ignores emulation enable
// - Output interrupt while output buffer loaded
// - Aux flag picks mouse over keyboard line
// - Character pending raises condition when empty
// - Bit 1 live view of condition
// - Emulation enable gates port decode
// - Emulation enable lets loaded input raise emulation interrupt
// - Port writes captured into input data
// - Control register at 100H, word access
// - Input data register at 104H, word access
// - Data port read clears output loaded
// - Port write sets input loaded, except A20
// - Input loaded with emulation raises condition
// - Data write clears, command write sets flag
module lke_top
#(
	parameter int IO_AW = 16 // Host I/O address width
)
(
	input wire logic hclk, // Block clock
	input wire logic hresetn, // Asynchronous reset, active low
	input wire logic hsel, // AHB slave select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB transfer size
	input wire logic hready, // AHB bus ready
	input wire logic [31:0] hwdata, // AHB write data
	output logic [31:0] hrdata, // AHB read data
	output logic hreadyout, // AHB slave ready
	output logic hresp, // AHB response
	input wire logic [IO_AW-1:0] io_addr, // Host I/O address
	input wire logic io_wr, // Host I/O write strobe
	input wire logic io_rd, // Host I/O read strobe
	input wire logic [7:0] io_wdata, // Host I/O write byte
	output logic [7:0] io_rdata, // Host I/O read byte
	input wire logic kbc_kbd_irq, // Controller keyboard interrupt
	input wire logic kbc_mouse_irq, // Controller mouse interrupt
	input wire logic kbc_a20_level, // Controller gate A20 level
	output logic keyboard_interrupt_line, // Emulated keyboard interrupt
	output logic mouse_interrupt_line, // Emulated mouse interrupt
	output logic emul_irq // Emulation interrupt to software
);

	// Refuse widths the 16-bit port compare cannot serve without aliasing
	if (IO_AW < 8 || IO_AW > 16)
	begin : g_check
		$error("lke_top: IO_AW must be 8 to 16");
	end

	// Control register state
	logic legacy_emulation_on; // Port decode enable
	logic pending_char_request; // Ask for a character
	logic output_irq_enable; // Drive emulated interrupts
	logic external_irq_passthrough_enable; // Route controller lines
	logic a20_gate_sequence; // Gate A20 command seen
	logic kbd_irq_edge_seen; // Keyboard edge flag
	logic mouse_irq_edge_seen; // Mouse edge flag

	// Data registers
	logic [7:0] legacy_input_data; // Last byte from host
	logic [7:0] legacy_output_data; // Byte returned on port read

	// Status register state
	logic out_buffer_loaded; // Output byte waiting
	logic in_buffer_loaded; // Input byte waiting
	logic aux_buffer_loaded; // Waiting byte is from mouse
	logic last_write_was_command; // Last write hit command port
	logic sys_flag; // Software boot flag
	logic inhibit_off; // Keyboard not inhibited
	logic timeout_seen; // Software timeout flag
	logic parity_seen; // Software parity flag
	logic [7:0] legacy_status_reg; // Status byte as read

	// Bus pipeline
	logic dp_write; // Data phase write pending
	logic [11:0] dp_addr; // Data phase address
	logic addr_phase; // Valid address phase this cycle
	logic wr_ctrl; // Control register write
	logic wr_input; // Input register write
	logic wr_output; // Output register write
	logic wr_status; // Status register write

	// Decoded host port strobes
	logic wr_data; // Write to data port
	logic wr_cmd; // Write to command port
	logic rd_data; // Read of data port
	logic rd_cmd; // Read of command port

	// Interrupt terms
	logic a20_mismatch; // Data byte asks for new A20 level
	logic emul_cond; // Emulation interrupt condition
	logic [31:0] ctrl_word; // Control register as read
	logic [31:0] next_hrdata; // Read data for next data phase

	// Host port decode, only while emulation is on
	lke_io_decode #(
		.IO_AW(IO_AW)
	) u_decode (
		.io_addr(io_addr),
		.io_wr(io_wr),
		.io_rd(io_rd),
		.enable(legacy_emulation_on),
		.wr_data(wr_data),
		.wr_cmd(wr_cmd),
		.rd_data(rd_data),
		.rd_cmd(rd_cmd)
	);

	// Write strobes, taken in the data phase
	assign wr_ctrl = dp_write && (dp_addr == `LKE_OFF_CTRL);
	assign wr_input = dp_write && (dp_addr == `LKE_OFF_INPUT);
	assign wr_output = dp_write && (dp_addr == `LKE_OFF_OUTPUT);
	assign wr_status = dp_write && (dp_addr == `LKE_OFF_STATUS);

	// Edge flags; a write of 1 clears, a 0 leaves them alone
	lke_edge_flag u_kbd_edge (
		.clk(hclk),
		.rst_n(hresetn),
		.level(kbc_kbd_irq),
		.clr(wr_ctrl && hwdata[`LKE_CTRL_KBD_SEEN]),
		.flag(kbd_irq_edge_seen)
	);

	lke_edge_flag u_mouse_edge (
		.clk(hclk),
		.rst_n(hresetn),
		.level(kbc_mouse_irq),
		.clr(wr_ctrl && hwdata[`LKE_CTRL_MOUSE_SEEN]),
		.flag(mouse_irq_edge_seen)
	);

	// Address phase capture; only whole-word transfers are meant
	assign addr_phase = hsel && hready && htrans[1];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_write <= 1'b0;
			dp_addr <= 12'h000;
		end
		else
		begin
			dp_write <= addr_phase && hwrite && (hsize == 3'h2);
			dp_addr <= haddr[11:0];
		end
	end

	// Slave never stalls and always answers OKAY
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Software-owned control bits; reserved bits are dropped
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			legacy_emulation_on <= 1'b0;
			pending_char_request <= 1'b0;
			output_irq_enable <= 1'b0;
			external_irq_passthrough_enable <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			legacy_emulation_on <= hwdata[`LKE_CTRL_EMU_ON];
			pending_char_request <= hwdata[`LKE_CTRL_CHAR_PEND];
			output_irq_enable <= hwdata[`LKE_CTRL_IRQ_EN];
			external_irq_passthrough_enable <= hwdata[`LKE_CTRL_EXT_EN];
		end
	end

	// Gate A20 sequence follows command port bytes only
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			a20_gate_sequence <= 1'b0;
		else if (wr_cmd)
			a20_gate_sequence <= (io_wdata == `LKE_A20_CMD);
	end

	// Captured host byte; a host write wins over software
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			legacy_input_data <= `LKE_BYTE_RESET;
		else if (wr_data || wr_cmd)
			legacy_input_data <= io_wdata;
		else if (wr_input)
			legacy_input_data <= hwdata[7:0];
	end

	// Byte that emulation software offers to the host
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			legacy_output_data <= `LKE_BYTE_RESET;
		else if (wr_output)
			legacy_output_data <= hwdata[7:0];
	end

	// Only a byte asking for a new A20 level needs software
	assign a20_mismatch = io_wdata[`LKE_A20_DATA_BIT] != kbc_a20_level;

	// Input loaded: set by host writes, cleared by software
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			in_buffer_loaded <= 1'b0;
		else if (wr_cmd || (wr_data && (!a20_gate_sequence || a20_mismatch)))
			in_buffer_loaded <= 1'b1;
		else if (wr_status)
			in_buffer_loaded <= hwdata[`LKE_ST_IN_FULL];
	end

	// Output loaded: host read of the data port empties it
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			out_buffer_loaded <= 1'b0;
		else if (rd_data)
			out_buffer_loaded <= 1'b0;
		else if (wr_status)
			out_buffer_loaded <= hwdata[`LKE_ST_OUT_FULL];
	end

	// Command or data marker of the last host write
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			last_write_was_command <= 1'b0;
		else if (wr_data)
			last_write_was_command <= 1'b0;
		else if (wr_cmd)
			last_write_was_command <= 1'b1;
		else if (wr_status)
			last_write_was_command <= hwdata[`LKE_ST_CMD];
	end

	// Plain software-held status bits
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			aux_buffer_loaded <= 1'b0;
			sys_flag <= 1'b0;
			inhibit_off <= 1'b0;
			timeout_seen <= 1'b0;
			parity_seen <= 1'b0;
		end
		else if (wr_status)
		begin
			aux_buffer_loaded <= hwdata[`LKE_ST_AUX_FULL];
			sys_flag <= hwdata[`LKE_ST_FLAG];
			inhibit_off <= hwdata[`LKE_ST_INHIBIT];
			timeout_seen <= hwdata[`LKE_ST_TIMEOUT];
			parity_seen <= hwdata[`LKE_ST_PARITY];
		end
	end

	// Status byte as seen by both software and the host
	always_comb
	begin
		legacy_status_reg = `LKE_BYTE_RESET;
		legacy_status_reg[`LKE_ST_OUT_FULL] = out_buffer_loaded;
		legacy_status_reg[`LKE_ST_IN_FULL] = in_buffer_loaded;
		legacy_status_reg[`LKE_ST_FLAG] = sys_flag;
		legacy_status_reg[`LKE_ST_CMD] = last_write_was_command;
		legacy_status_reg[`LKE_ST_INHIBIT] = inhibit_off;
		legacy_status_reg[`LKE_ST_AUX_FULL] = aux_buffer_loaded;
		legacy_status_reg[`LKE_ST_TIMEOUT] = timeout_seen;
		legacy_status_reg[`LKE_ST_PARITY] = parity_seen;
	end

	// Emulation condition; pass-through does not need emulation on
	assign emul_cond =
		(external_irq_passthrough_enable && (kbc_kbd_irq || kbc_mouse_irq)) ||
		(legacy_emulation_on && in_buffer_loaded) ||
		(pending_char_request && !out_buffer_loaded);

	// Host reads return the output byte or the status byte
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			io_rdata <= `LKE_BYTE_RESET;
		else if (rd_data)
			io_rdata <= legacy_output_data;
		else if (rd_cmd)
			io_rdata <= legacy_status_reg;
	end

	// Emulated interrupts, held while a byte is waiting
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			keyboard_interrupt_line <= 1'b0;
			mouse_interrupt_line <= 1'b0;
		end
		else
		begin
			keyboard_interrupt_line <= output_irq_enable && out_buffer_loaded &&
				!aux_buffer_loaded;
			mouse_interrupt_line <= output_irq_enable && out_buffer_loaded &&
				aux_buffer_loaded;
		end
	end

	// Emulation interrupt output, one flop behind the condition
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			emul_irq <= 1'b0;
		else
			emul_irq <= emul_cond;
	end

	// Control word: bit 1 is live, bit 8 follows the controller
	always_comb
	begin
		ctrl_word = `LKE_WORD_ZERO;
		ctrl_word[`LKE_CTRL_EMU_ON] = legacy_emulation_on;
		ctrl_word[`LKE_CTRL_EMU_IRQ] = emul_cond;
		ctrl_word[`LKE_CTRL_CHAR_PEND] = pending_char_request;
		ctrl_word[`LKE_CTRL_IRQ_EN] = output_irq_enable;
		ctrl_word[`LKE_CTRL_EXT_EN] = external_irq_passthrough_enable;
		ctrl_word[`LKE_CTRL_A20_SEQ] = a20_gate_sequence;
		ctrl_word[`LKE_CTRL_KBD_SEEN] = kbd_irq_edge_seen;
		ctrl_word[`LKE_CTRL_MOUSE_SEEN] = mouse_irq_edge_seen;
		ctrl_word[`LKE_CTRL_A20_LEVEL] = kbc_a20_level;
	end

	// Read mux; unmapped offsets read as zero
	always_comb
	begin
		next_hrdata = `LKE_WORD_ZERO;
		case (haddr[11:0])
			`LKE_OFF_CTRL: next_hrdata = ctrl_word;
			`LKE_OFF_INPUT: next_hrdata = {24'h000000, legacy_input_data};
			`LKE_OFF_OUTPUT: next_hrdata = {24'h000000, legacy_output_data};
			`LKE_OFF_STATUS: next_hrdata = {24'h000000, legacy_status_reg};
			default: next_hrdata = `LKE_WORD_ZERO;
		endcase
	end

	// Read data is sampled at the address phase, held otherwise
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= `LKE_WORD_ZERO;
		else if (addr_phase && !hwrite)
			hrdata <= next_hrdata;
	end

endmodule

/* verif/lke_kbc_model.sv */
/*
 Keyboard controller model: drives the two interrupt levels and the
 gate A20 level seen by the emulation block.
 Assumes the bench sets the request levels just after a rising edge.
*/
`timescale 1ns/1ps

module lke_kbc_model
(
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset, active low
	input wire logic kbd_req, // Wanted keyboard level
	input wire logic mouse_req, // Wanted mouse level
	input wire logic a20_req, // Wanted A20 level
	output logic kbd_irq, // Keyboard interrupt level
	output logic mouse_irq, // Mouse interrupt level
	output logic a20_level // Gate A20 level
);
	// Lines come from flops, as in a real controller, so no glitch reaches the block
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			{kbd_irq, mouse_irq, a20_level} <= 3'h0;
		else
			{kbd_irq, mouse_irq, a20_level} <= {kbd_req, mouse_req, a20_req};
endmodule

/* verif/lke_top_properties.sv */
/*
 Port-level checker of the legacy keyboard emulation top.
 Assumes one zero-wait AHB-Lite master and a single clock.
*/
`timescale 1ns/1ps
`include "lke_regs.svh"

module lke_top_properties
#(
	parameter int IO_AW = 16 // Host I/O address width
)
(
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset
	input wire logic hsel, // Select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Transfer
	input wire logic hwrite, // Write
	input wire logic [2:0] hsize, // Size
	input wire logic hready, // Ready in
	input wire logic [31:0] hwdata, // Write data
	input wire logic [31:0] hrdata, // Read data
	input wire logic hreadyout, // Ready out
	input wire logic hresp, // Response
	input wire logic [IO_AW-1:0] io_addr, // I/O address
	input wire logic io_wr, // I/O write
	input wire logic io_rd, // I/O read
	input wire logic [7:0] io_wdata, // I/O byte
	input wire logic [7:0] io_rdata, // I/O read byte
	input wire logic kbc_kbd_irq, // Keyboard level
	input wire logic kbc_mouse_irq, // Mouse level
	input wire logic kbc_a20_level, // A20 level
	input wire logic keyboard_interrupt_line, // Keyboard out
	input wire logic mouse_interrupt_line, // Mouse out
	input wire logic emul_irq // Emulation interrupt
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic dp_wr; // Write in data phase
	logic dp_rd; // Read in data phase
	logic [11:0] dp_a; // Data phase address
	logic emu_on, pend, irq_en, pass_en; // Mirrored control bits
	logic rd_map; // Data phase hits a register

	// Address phase capture; only word writes count
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			{dp_wr, dp_rd, dp_a} <= 14'h0000;
		else if (hready)
			{dp_wr, dp_rd, dp_a} <= {hsel && htrans[1] && hwrite && hsize == 3'h2, hsel && htrans[1] && !hwrite, haddr[11:0]};

	// Mirror of the enables, so interrupt outputs can be tied to their cause
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			{pass_en, irq_en, pend, emu_on} <= 4'h0;
		else if (dp_wr && dp_a == `LKE_OFF_CTRL)
			{pass_en, irq_en, pend, emu_on} <= {hwdata[4:2], hwdata[0]};

	assign rd_map = dp_a inside {`LKE_OFF_CTRL, `LKE_OFF_INPUT, `LKE_OFF_OUTPUT, `LKE_OFF_STATUS};

	AST_BUS_OKAY: assert property (hreadyout && !hresp)
		else $error("bus answer not ready and okay");
	AST_CTRL_RSVD: assert property (dp_rd && dp_a == `LKE_OFF_CTRL |-> hrdata[31:9] == 23'h000000)
		else $error("control reserved bits not zero");
	AST_INPUT_RSVD: assert property (dp_rd && dp_a == `LKE_OFF_INPUT |-> hrdata[31:8] == 24'h000000)
		else $error("input data reserved bits not zero");
	AST_UNMAPPED: assert property (dp_rd && !rd_map |-> hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	AST_PASS_KBD: assert property (pass_en && kbc_kbd_irq |=> emul_irq)
		else $error("keyboard level not passed through");
	AST_PASS_MOUSE: assert property (pass_en && kbc_mouse_irq |=> emul_irq)
		else $error("mouse level not passed through");
	AST_NO_IRQ_EN: assert property (!irq_en [*2] |-> !keyboard_interrupt_line && !mouse_interrupt_line)
		else $error("interrupt line without enable");
	AST_LINES_ONEHOT: assert property (!(keyboard_interrupt_line && mouse_interrupt_line))
		else $error("both interrupt lines high");
	AST_QUIET: assert property (!emu_on && !pend && !pass_en |=> !emul_irq)
		else $error("emulation interrupt with all sources off");
	AST_IO_OFF: assert property (!emu_on && io_rd |=> $stable(io_rdata))
		else $error("port read answered while emulation off");

	COV_PASS: cover property (pass_en && emul_irq);
	COV_KBD: cover property (keyboard_interrupt_line);
	COV_MOUSE: cover property (mouse_interrupt_line);
endmodule

/* verif/lke_top_test.sv */
/*
 Self-checking bench of the legacy keyboard emulation top.
 Assumes the controller model beside it and the checker bound below.
*/
`timescale 1ns/1ps
`include "lke_regs.svh"

module lke_top_test;
	logic hclk, hresetn, hsel, hwrite, io_wr, io_rd; // Bench drives
	logic kreq, mreq, areq; // Controller model requests
	logic [31:0] haddr, hwdata, hrdata, q; // Bus data
	logic [1:0] htrans; // Transfer type
	logic [2:0] hsize; // Transfer size
	logic [15:0] io_addr; // Legacy port
	logic [7:0] io_wdata, io_rdata; // Port bytes
	logic hreadyout, hresp, kbd, mouse, a20; // Design and model outputs
	logic kline, mline, emul_irq; // Interrupt outputs
	int bad_count, tests_run; // Counters

	lke_kbc_model kbc (.hclk, .hresetn, .kbd_req(kreq), .mouse_req(mreq), .a20_req(areq),
		.kbd_irq(kbd), .mouse_irq(mouse), .a20_level(a20));
	lke_top #(.IO_AW(16)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .io_addr, .io_wr, .io_rd,
		.io_wdata, .io_rdata, .kbc_kbd_irq(kbd), .kbc_mouse_irq(mouse), .kbc_a20_level(a20),
		.keyboard_interrupt_line(kline), .mouse_interrupt_line(mline), .emul_irq);

	// Single closing point for the run
	task give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", nm, exp, got);
			bad_count++;
		end
	endtask

	task idle(input int n);
		repeat (n) @(posedge hclk);
	endtask

	// Bounded wait for hready; a hang counts against the run
	task wait_rdy;
		int n;
		n = 0;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
		if (hreadyout !== 1'b1)
		begin
			bad_count++;
			give_verdict;
		end
	endtask

	// One single word transfer: address phase, then data phase
	task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
		@(posedge hclk);
		{hsel, htrans, haddr, hwrite, hsize} <= {1'b1, 2'b10, a, wr, 3'h2};
		wait_rdy;
		{hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
		wait_rdy;
		rd = hrdata;
	endtask

	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask

	task rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0, q);
		chk(nm, exp, q);
	endtask

	// One-cycle host I/O strobe
	task io(input logic rd, input logic [15:0] a, input logic [7:0] b);
		@(posedge hclk);
		{io_wr, io_rd, io_addr, io_wdata} <= {!rd, rd, a, b};
		@(posedge hclk);
		{io_wr, io_rd} <= 2'b00;
	endtask

	task t_reset;
		rdc("ctrl", `LKE_OFF_CTRL, 32'h0);
		rdc("unmapped", 32'h0000_0200, 32'h0);
		wr(`LKE_OFF_CTRL, 32'hFFFF_FE01);
		rdc("ctrl", `LKE_OFF_CTRL, 32'h1);
		@(posedge hclk) areq <= 1'b1;
		idle(3);
		rdc("ctrl", `LKE_OFF_CTRL, 32'h101);
	endtask

	// Gate A20 command, matching and differing data bytes, then another command
	task t_a20;
		io(1'b0, `LKE_PORT_CMD, 8'hD1);
		rdc("ctrl", `LKE_OFF_CTRL, 32'h123);
		rdc("input", `LKE_OFF_INPUT, 32'hD1);
		rdc("status", `LKE_OFF_STATUS, 32'h0A);
		wr(`LKE_OFF_STATUS, 32'h0);
		io(1'b0, `LKE_PORT_DATA, 8'h02);
		rdc("status", `LKE_OFF_STATUS, 32'h0);
		rdc("input", `LKE_OFF_INPUT, 32'h02);
		io(1'b0, `LKE_PORT_DATA, 8'h00);
		rdc("status", `LKE_OFF_STATUS, 32'h02);
		io(1'b0, `LKE_PORT_CMD, 8'hAA);
		rdc("ctrl", `LKE_OFF_CTRL, 32'h103);
		chk("emul_irq", 32'h1, emul_irq);
	endtask

	task t_off;
		wr(`LKE_OFF_CTRL, 32'h0);
		wr(`LKE_OFF_STATUS, 32'hD4);
		wr(`LKE_OFF_OUTPUT, 32'h5A);
		io(1'b0, `LKE_PORT_DATA, 8'h55);
		io(1'b1, `LKE_PORT_DATA, 8'h00);
		idle(1);
		chk("io_rdata", 32'h0, io_rdata);
		rdc("input", `LKE_OFF_INPUT, 32'hAA);
		rdc("status", `LKE_OFF_STATUS, 32'hD4);
	endtask

	// Edge flags, write-one-to-clear, then pass-through with emulation off
	task t_edges;
		@(posedge hclk) kreq <= 1'b1;
		idle(3);
		rdc("ctrl", `LKE_OFF_CTRL, 32'h140);
		wr(`LKE_OFF_CTRL, 32'h0);
		rdc("ctrl", `LKE_OFF_CTRL, 32'h140);
		wr(`LKE_OFF_CTRL, 32'h40);
		rdc("ctrl", `LKE_OFF_CTRL, 32'h100);
		@(posedge hclk) mreq <= 1'b1;
		idle(3);
		rdc("ctrl", `LKE_OFF_CTRL, 32'h180);
		wr(`LKE_OFF_CTRL, 32'h80);
		rdc("ctrl", `LKE_OFF_CTRL, 32'h100);
		wr(`LKE_OFF_CTRL, 32'h10);
		idle(2);
		chk("emul_irq", 32'h1, emul_irq);
		@(posedge hclk) kreq <= 1'b0;
		idle(3);
		chk("emul_irq", 32'h1, emul_irq);
		@(posedge hclk) mreq <= 1'b0;
		idle(3);
		chk("emul_irq", 32'h0, emul_irq);
	endtask

	// Output buffer interrupts, data port read, character pending
	task t_outirq;
		wr(`LKE_OFF_STATUS, 32'h01);
		wr(`LKE_OFF_CTRL, 32'h08);
		idle(2);
		chk("irq lines", 32'h2, {kline, mline});
		wr(`LKE_OFF_STATUS, 32'h21);
		idle(2);
		chk("irq lines", 32'h1, {kline, mline});
		wr(`LKE_OFF_CTRL, 32'h09);
		io(1'b1, `LKE_PORT_DATA, 8'h00);
		rdc("status", `LKE_OFF_STATUS, 32'h20);
		chk("io_rdata", 32'h5A, io_rdata);
		chk("irq lines", 32'h0, {kline, mline});
		wr(`LKE_OFF_CTRL, 32'h04);
		idle(2);
		chk("emul_irq", 32'h1, emul_irq);
		rdc("ctrl", `LKE_OFF_CTRL, 32'h106);
		wr(`LKE_OFF_STATUS, 32'h01);
		idle(2);
		chk("emul_irq", 32'h0, emul_irq);
	endtask

	// Free-running clock at 200 MHz
	initial
	begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	// Main sequence
	initial
	begin
		{hresetn, hsel, hwrite, io_wr, io_rd, kreq, mreq, areq} = 8'h00;
		{haddr, hwdata, htrans, hsize, io_addr, io_wdata} = 93'h0;
		bad_count = 0;
		tests_run = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_a20;
		t_off;
		t_edges;
		t_outirq;
		give_verdict;
	end
endmodule

bind lke_top lke_top_properties #(.IO_AW(IO_AW)) props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
	.kbc_kbd_irq, .kbc_mouse_irq, .kbc_a20_level, .keyboard_interrupt_line, .mouse_interrupt_line, .emul_irq);
